// ==== hdl/timer_channel_pkg.sv ====
/*
  Constants and carriers shared by the timer channel status block.
  Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
package timer_channel_pkg;
  localparam int ADDR_W  = 8;
  localparam int VAL_W   = 16;
  localparam int N_FLAGS = 8;

  localparam logic [ADDR_W-1:0] OFS_CFG   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CCA   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CCB   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMPC  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SR    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IER   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IDR   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IMR   = 8'h2C;

  localparam int SR_OVF  = 0;
  localparam int SR_LOVR = 1;
  localparam int SR_CPA  = 2;
  localparam int SR_CPB  = 3;
  localparam int SR_CPC  = 4;
  localparam int SR_LDA  = 5;
  localparam int SR_LDB  = 6;
  localparam int SR_ETRG = 7;
  localparam int SR_CLK  = 16;
  localparam int SR_MA   = 17;
  localparam int SR_MB   = 18;

  localparam int CFG_ACT_B    = 0;
  localparam int CFG_ACT_C    = 2;
  localparam int CFG_ACT_EXT  = 4;
  localparam int CFG_ACT_SOFT = 6;
  localparam int CFG_EVT_SRC  = 8;
  localparam int CFG_WAVE     = 15;

  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_SET    = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  localparam logic [1:0] EVT_SRC_LINE_B = 2'h0;

  localparam logic [VAL_W-1:0]   VAL_RST   = 16'h0000;
  localparam logic [N_FLAGS-1:0] FLAG_RST  = 8'h00;
  localparam logic [N_FLAGS-1:0] MASK_RST  = 8'h00;
  // flags that only exist in one mode
  localparam logic [N_FLAGS-1:0] CAPT_ONLY = 8'h62;
  localparam logic [N_FLAGS-1:0] WAVE_ONLY = 8'h0C;

  typedef struct packed {
    logic [1:0] onSoft;
    logic [1:0] onExt;
    logic [1:0] onC;
    logic [1:0] onB;
  } lineb_act_s;

  // event pulses from the counter, clock and trigger logic
  typedef struct packed {
    logic tick;
    logic overflow;
    logic loadA;
    logic loadB;
    logic extTrigger;
    logic extEvent;
    logic softTrigger;
  } chan_evt_s;
endpackage : timer_channel_pkg

// ==== hdl/line_action.sv ====
/*
  One step of the output line action chain: none, set, clear or toggle.
  Assumes the caller orders instances from lowest to highest priority.
*/
`timescale 1ns/10ps
module line_action
  import timer_channel_pkg::*;
(
  input  wire logic       cur,
  input  wire logic       hit,
  input  wire logic [1:0] act,
  output logic            nxt
);
  always_comb
  begin
    nxt = cur;
    if (hit)
    begin
      case (act)
        ACT_SET:    nxt = 1'b1;
        ACT_CLEAR:  nxt = 1'b0;
        ACT_TOGGLE: nxt = ~cur;
        default:    nxt = cur;
      endcase
    end
  end
endmodule : line_action

// ==== hdl/timer_channel_status.sv ====
/*
  Timer channel status, compare/capture registers and second line actions.
  Assumes counter, clock select and trigger logic outside on the same clock,
  delivering one-cycle event pulses and the live counter value.
*/
// The placing of the registers and the APB slave port are this design's own decisions.
// What this block does
// - waveform mode: B and C matches apply none/set/clear/toggle to line B
// - external event and software trigger apply the same codes to line B
// - counter value register shows the live 16-bit count
// - registers A and B read-only in capture, read/write in waveform mode
// - register C readable and writable in both modes
// - overflow flag bit 0 sticks until status read
// - capture: load overrun bit 1 on double load without read
// - waveform: match A bit 2, match B bit 3, zero in capture
// - match C flag bit 4 in both modes, cleared by status read
// - capture: load A bit 5, load B bit 6, zero in waveform
// - external trigger flag bit 7, cleared by status read
// - bit 16 shows counter clock enabled, not cleared by read
// - bits 17 and 18 mirror lines A and B, pin or driven level
// - enable register write sets mask bits written one
// - disable register write clears mask bits written one
// - mask register reads the eight enabled sources
// - line B as event source becomes input, no waveform
// - mode bit 0 capture, 1 waveform
`timescale 1ns/10ps
module timer_channel_status
  import timer_channel_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                arst_n,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [timer_channel_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [timer_channel_pkg::VAL_W-1:0] counterValue,
  input  wire timer_channel_pkg::chan_evt_s        evt,
  input  wire logic                                counterClockOn,
  input  wire logic                                lineADriven,
  input  wire logic                                timerLineAIn,
  input  wire logic                                timerLineBIn,
  output logic                                     timerLineBOut,
  output logic                                     timerLineBOe,
  output logic                                     waveMode,
  output logic                                     irq
);
  import timer_channel_pkg::*;

  logic                setup;
  logic                access;
  logic                wrAcc;
  logic                rdAcc;
  logic [31:0]         rdNxt;
  logic                errNxt;
  logic                pready_r;
  logic [31:0]         prdata_r;
  logic                pslverr_r;
  lineb_act_s          act_r;
  logic [1:0]          evtSrc_r;
  logic                wave_r;
  logic [VAL_W-1:0]    regA_r;
  logic [VAL_W-1:0]    regB_r;
  logic [VAL_W-1:0]    regC_r;
  logic                aUnread_r;
  logic                bUnread_r;
  logic [N_FLAGS-1:0]  flags_r;
  logic [N_FLAGS-1:0]  flags_nxt;
  logic [N_FLAGS-1:0]  setEvt;
  logic [N_FLAGS-1:0]  clrMask;
  logic [N_FLAGS-1:0]  mask_r;
  logic [N_FLAGS-1:0]  mask_nxt;
  logic                irq_r;
  logic [1:0]          lineASync_r;
  logic [1:0]          lineBSync_r;
  logic                lineBOut_r;
  logic                lineBOe_r;
  logic                driveB;
  logic                matchA;
  logic                matchB;
  logic                matchC;
  logic [3:0]          hits;
  logic [7:0]          acts;
  logic [4:0]          chain;

  assign setup  = psel && !penable;
  assign access = psel && penable && pready_r;
  assign wrAcc  = access && pwrite;
  assign rdAcc  = access && !pwrite;

  // one wait-free access phase: ready rises for the cycle after setup
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup && errNxt;
    end
  end

  // data sampled in setup; the status clear uses exactly this snapshot
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata_r <= 32'h0000_0000;
    else if (setup)
      prdata_r <= pwrite ? 32'h0000_0000 : rdNxt;
  end

  always_comb
  begin
    rdNxt  = 32'h0000_0000;
    errNxt = 1'b0;
    if (paddr == OFS_CFG)
    begin
      rdNxt[CFG_ACT_B +: 8]   = act_r;
      rdNxt[CFG_EVT_SRC +: 2] = evtSrc_r;
      rdNxt[CFG_WAVE]         = wave_r;
    end
    else if (paddr == OFS_COUNT)
      rdNxt[VAL_W-1:0] = counterValue;
    else if (paddr == OFS_CCA)
      rdNxt[VAL_W-1:0] = regA_r;
    else if (paddr == OFS_CCB)
      rdNxt[VAL_W-1:0] = regB_r;
    else if (paddr == OFS_CMPC)
      rdNxt[VAL_W-1:0] = regC_r;
    else if (paddr == OFS_SR)
    begin
      rdNxt[N_FLAGS-1:0] = flags_r & ~(wave_r ? CAPT_ONLY : WAVE_ONLY);
      rdNxt[SR_CLK]      = counterClockOn;
      rdNxt[SR_MA]       = wave_r ? lineADriven : lineASync_r[1];
      rdNxt[SR_MB]       = lineBOe_r ? lineBOut_r : lineBSync_r[1];
    end
    else if (paddr == OFS_IMR)
      rdNxt[N_FLAGS-1:0] = mask_r;
    else if (paddr == OFS_IER || paddr == OFS_IDR)
      rdNxt = 32'h0000_0000;
    else
      errNxt = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      act_r    <= '0;
      evtSrc_r <= EVT_SRC_LINE_B;
      wave_r   <= 1'b0;
    end
    else if (wrAcc && paddr == OFS_CFG)
    begin
      act_r    <= pwdata[CFG_ACT_B +: 8];
      evtSrc_r <= pwdata[CFG_EVT_SRC +: 2];
      wave_r   <= pwdata[CFG_WAVE];
    end
  end

  // capture loads win over a software write; software writes to A and B are waveform only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regA_r <= VAL_RST;
      regB_r <= VAL_RST;
      regC_r <= VAL_RST;
    end
    else
    begin
      if (!wave_r && evt.loadA)
        regA_r <= counterValue;
      else if (wave_r && wrAcc && paddr == OFS_CCA)
        regA_r <= pwdata[VAL_W-1:0];
      if (!wave_r && evt.loadB)
        regB_r <= counterValue;
      else if (wave_r && wrAcc && paddr == OFS_CCB)
        regB_r <= pwdata[VAL_W-1:0];
      if (wrAcc && paddr == OFS_CMPC)
        regC_r <= pwdata[VAL_W-1:0];
    end
  end

  // unread tracking for overrun; a load in the read cycle keeps it pending
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aUnread_r <= 1'b0;
      bUnread_r <= 1'b0;
    end
    else
    begin
      aUnread_r <= !wave_r && (evt.loadA || (aUnread_r && !(rdAcc && paddr == OFS_CCA)));
      bUnread_r <= !wave_r && (evt.loadB || (bUnread_r && !(rdAcc && paddr == OFS_CCB)));
    end
  end

  assign matchA = wave_r && evt.tick && counterValue == regA_r;
  assign matchB = wave_r && evt.tick && counterValue == regB_r;
  assign matchC = evt.tick && counterValue == regC_r;

  always_comb
  begin
    setEvt          = '0;
    setEvt[SR_OVF]  = evt.overflow;
    setEvt[SR_LOVR] = !wave_r && ((evt.loadA && aUnread_r) || (evt.loadB && bUnread_r));
    setEvt[SR_CPA]  = matchA;
    setEvt[SR_CPB]  = matchB;
    setEvt[SR_CPC]  = matchC;
    setEvt[SR_LDA]  = !wave_r && evt.loadA;
    setEvt[SR_LDB]  = !wave_r && evt.loadB;
    setEvt[SR_ETRG] = evt.extTrigger;
  end

  // only bits actually reported are cleared, so a set never gets lost
  assign clrMask = (rdAcc && paddr == OFS_SR) ? prdata_r[N_FLAGS-1:0] : '0;

  always_comb
  begin
    flags_nxt = (flags_r & ~clrMask) | setEvt;
    if (wave_r)
      flags_nxt = flags_nxt & ~CAPT_ONLY;
    else
      flags_nxt = flags_nxt & ~WAVE_ONLY;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flags_r <= FLAG_RST;
    else
      flags_r <= flags_nxt;
  end

  always_comb
  begin
    mask_nxt = mask_r;
    if (wrAcc && paddr == OFS_IER)
      mask_nxt = mask_r | pwdata[N_FLAGS-1:0];
    else if (wrAcc && paddr == OFS_IDR)
      mask_nxt = mask_r & ~pwdata[N_FLAGS-1:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_r <= MASK_RST;
      irq_r  <= 1'b0;
    end
    else
    begin
      mask_r <= mask_nxt;
      irq_r  <= |(flags_nxt & mask_nxt);
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lineASync_r <= 2'b00;
      lineBSync_r <= 2'b00;
    end
    else
    begin
      lineASync_r <= {lineASync_r[0], timerLineAIn};
      lineBSync_r <= {lineBSync_r[0], timerLineBIn};
    end
  end

  assign driveB = wave_r && evtSrc_r != EVT_SRC_LINE_B;
  // lowest priority first: B match, C match, external event, software trigger
  assign hits   = {evt.softTrigger, evt.extEvent, matchC, matchB} & {4{driveB}};
  assign acts   = {act_r.onSoft, act_r.onExt, act_r.onC, act_r.onB};
  assign chain[0] = lineBOut_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_act
      line_action u_act
      (
        .cur (chain[gi]),
        .hit (hits[gi]),
        .act (acts[2*gi +: 2]),
        .nxt (chain[gi+1])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lineBOut_r <= 1'b0;
      lineBOe_r  <= 1'b0;
    end
    else
    begin
      lineBOut_r <= chain[4];
      lineBOe_r  <= driveB;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign timerLineBOut = lineBOut_r;
  assign timerLineBOe  = lineBOe_r;
  assign waveMode      = wave_r;
  assign irq           = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence statusRead;
    rdAcc && paddr == OFS_SR;
  endsequence

  sequence softToggle;
    lineBOe_r && driveB && evt.softTrigger && act_r.onSoft == ACT_TOGGLE && hits[2:0] == 3'h0;
  endsequence

  a_ovf_sticky: assert property (evt.overflow |=> flags_r[SR_OVF])
    else $error("overflow flag not set");
  a_status_clear: assert property (statusRead ##0 (prdata_r[SR_ETRG] && !evt.extTrigger)
      |=> !flags_r[SR_ETRG])
    else $error("trigger flag not cleared by status read");
  a_irq_level: assert property (irq_r == |(flags_r & mask_r))
    else $error("interrupt does not follow enabled flags");
  a_mask_enable: assert property (wrAcc && paddr == OFS_IER
      |=> (mask_r & $past(pwdata[N_FLAGS-1:0])) == $past(pwdata[N_FLAGS-1:0]))
    else $error("enable write did not set mask");
  a_mask_disable: assert property (wrAcc && paddr == OFS_IDR
      |=> (mask_r & $past(pwdata[N_FLAGS-1:0])) == '0)
    else $error("disable write did not clear mask");
  a_capture_ro: assert property (wrAcc && paddr == OFS_CCA && !wave_r && !evt.loadA
      |=> $stable(regA_r))
    else $error("register A written in capture mode");
  a_lineb_input: assert property (evtSrc_r == EVT_SRC_LINE_B [*2] |-> !lineBOe_r)
    else $error("line B driven while used as event input");
  a_soft_toggle: assert property (softToggle |=> lineBOut_r != $past(lineBOut_r))
    else $error("software trigger toggle not applied");
  a_overrun_set: assert property (!wave_r && evt.loadA && aUnread_r |=> flags_r[SR_LOVR])
    else $error("load overrun not flagged");
  a_wave_zero: assert property (wave_r && $past(wave_r)
      |-> (flags_r & CAPT_ONLY) == '0)
    else $error("capture flags set in waveform mode");
  a_match_c: assert property (evt.tick && counterValue == regC_r |=> flags_r[SR_CPC])
    else $error("match C flag not set");
endmodule : timer_channel_status

// ==== tb/line_partner.sv ====
/*
  Model of what stands outside the two channel lines.
  Assumes the bench commands the levels that outside drivers put on the pins.
*/
`timescale 1ns/10ps
module line_partner
(
  input  wire logic bOut,
  input  wire logic bOe,
  input  wire logic aLvl,
  input  wire logic bLvl,
  output logic      lineA,
  output logic      lineB
);
  assign lineA = aLvl;
  // the channel owns the pin only while it drives; else the outside level
  assign lineB = bOe ? bOut : bLvl;
endmodule : line_partner

// ==== tb/tb_timer_channel_status.sv ====
/*
  Self-checking bench for the timer channel status block.
  Assumes zero-wait APB answers and one-cycle event pulses on one clock.
*/
`timescale 1ns/10ps
module tb_timer_channel_status;
  import timer_channel_pkg::*;
  localparam logic [6:0]  E_TICK = 7'h40, E_OVF = 7'h20, E_LDA = 7'h10, E_LDB = 7'h08;
  localparam logic [6:0]  E_TRG  = 7'h04, E_EXT = 7'h02, E_SW = 7'h01;
  localparam logic [15:0] IDLE = 16'h7777, RAV = 16'h00A5, RBV = 16'h1234, RCV = 16'h0ABC;
  logic              clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, waveMode;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [15:0]       counterValue, rnd, r2, rcr;
  chan_evt_s         evt;
  logic              counterClockOn, lineADriven, timerLineAIn, timerLineBIn;
  logic              timerLineBOut, timerLineBOe, aLvl, bLvl, err, expB;
  logic [7:0]        mask;
  int                fail_count, num_checks, f, c;

  timer_channel_status u_dut (
    .clk            (clk),
    .arst_n         (arst_n),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .counterValue   (counterValue),
    .evt            (evt),
    .counterClockOn (counterClockOn),
    .lineADriven    (lineADriven),
    .timerLineAIn   (timerLineAIn),
    .timerLineBIn   (timerLineBIn),
    .timerLineBOut  (timerLineBOut),
    .timerLineBOe   (timerLineBOe),
    .waveMode       (waveMode),
    .irq            (irq)
  );

  line_partner u_line (
    .bOut  (timerLineBOut),
    .bOe   (timerLineBOe),
    .aLvl  (aLvl),
    .bLvl  (bLvl),
    .lineA (timerLineAIn),
    .lineB (timerLineBIn)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic act(input logic [1:0] cd, input logic cur);
    return cd == ACT_SET ? 1'b1 : cd == ACT_CLEAR ? 1'b0 : cd == ACT_TOGGLE ? !cur : cur;
  endfunction : act

  function automatic logic [31:0] cfgv(input logic w, input logic [1:0] s, input logic [7:0] a);
    return {16'h0000, w, 5'h00, s, a};
  endfunction : cfgv

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  // request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
    begin
      fail_count++;
      close_out();
    end
    // taken at the edge where pready is sampled high, then released
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic hit(input logic [15:0] v, input logic [6:0] e);
    @(posedge clk);
    counterValue <= v;
    evt <= chan_evt_s'(e);
    @(posedge clk);
    counterValue <= IDLE;
    evt <= '0;
    repeat (3) @(posedge clk);
  endtask : hit

  task automatic rdsr(input logic [7:0] e);
    apb(1'b0, OFS_SR, 32'h0);
    chk("status flags", {24'h0, e}, {24'h0, q[7:0]});
  endtask : rdsr

  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {evt, counterClockOn, lineADriven, aLvl, bLvl, expB, mask} = '0;
    counterValue = IDLE;
    rnd = 16'h0038;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, OFS_IMR, 32'h0);
    chk("mask after reset", 32'h0, q);
    chk("wave after reset", 32'h0, waveMode);
    done("reset");
    rnd = lfsr(rnd);
    rcr = rnd | 16'h0001;
    apb(1'b1, OFS_CMPC, {16'h0, rcr});
    apb(1'b0, OFS_CMPC, 32'h0);
    chk("reg c", {16'h0, rcr}, q);
    apb(1'b1, OFS_CCA, 32'h00005A5A);
    apb(1'b0, OFS_CCA, 32'h0);
    chk("reg a capture", 32'h0, q);
    rnd = lfsr(rnd);
    counterValue <= rnd;
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count", {16'h0, rnd}, q);
    counterValue <= IDLE;
    apb(1'b0, 8'hF0, 32'h0);
    chk("unmapped error", 32'h1, err);
    for (f = 0; f < 4; f++)
    begin
      rnd = lfsr(rnd);
      r2 = lfsr(rnd);
      apb(1'b1, OFS_IER, {16'h0, rnd});
      apb(1'b1, OFS_IDR, {16'h0, r2});
      mask = (mask | rnd[7:0]) & ~r2[7:0];
      apb(1'b0, OFS_IMR, 32'h0);
      chk("mask", {24'h0, mask}, q);
    end
    apb(1'b1, OFS_IDR, 32'h000000FF);
    done("registers");
    hit(16'h0000, E_TICK);
    rdsr(8'h00);
    hit(rcr, E_TICK);
    rdsr(8'h10);
    hit(IDLE, E_LDA);
    hit(IDLE, E_LDA);
    rdsr(8'h22);
    rdsr(8'h00);
    hit(IDLE, E_LDB | E_TRG);
    rdsr(8'hC0);
    apb(1'b1, OFS_IER, 32'h00000001);
    hit(IDLE, E_OVF);
    chk("irq raised", 32'h1, irq);
    rdsr(8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, irq);
    rdsr(8'h00);
    {counterClockOn, aLvl, bLvl} <= 3'h7;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_SR, 32'h0);
    apb(1'b0, OFS_SR, 32'h0);
    chk("clock and pins", 32'h7, q[18:16]);
    {counterClockOn, aLvl, bLvl} <= 3'h0;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_SR, 32'h0);
    chk("clock and pins low", 32'h0, q[18:16]);
    done("capture");
    apb(1'b1, OFS_CFG, cfgv(1'b1, 2'h1, 8'h00));
    apb(1'b1, OFS_CCA, {16'h0, RAV});
    apb(1'b1, OFS_CCB, {16'h0, RBV});
    apb(1'b1, OFS_CMPC, {16'h0, RCV});
    apb(1'b0, OFS_CCA, 32'h0);
    chk("reg a wave", {16'h0, RAV}, q);
    apb(1'b0, OFS_CCB, 32'h0);
    chk("reg b wave", {16'h0, RBV}, q);
    chk("wave mode", 32'h1, waveMode);
    for (f = 0; f < 4; f++)
      for (c = 0; c < 4; c++)
      begin
        apb(1'b1, OFS_CFG, cfgv(1'b1, 2'h1, 8'(c) << (2 * f)));
        hit(f == 0 ? RBV : f == 1 ? RCV : IDLE, f < 2 ? E_TICK : f == 2 ? E_EXT : E_SW);
        expB = act(2'(c), expB);
        chk("line b level", {31'h0, expB}, timerLineBOut);
        chk("line b driven", 32'h1, timerLineBOe);
      end
    apb(1'b0, OFS_SR, 32'h0);
    lineADriven <= 1'b1;
    hit(RAV, E_TICK);
    hit(IDLE, E_LDA);
    rdsr(8'h04);
    chk("mirrors wave", {30'h0, expB, 1'b1}, q[18:17]);
    hit(RBV, E_TICK);
    rdsr(8'h08);
    apb(1'b1, OFS_CFG, cfgv(1'b1, EVT_SRC_LINE_B, 8'h00));
    apb(1'b0, OFS_SR, 32'h0);
    chk("line b released", 32'h0, timerLineBOe);
    done("waveform");
    close_out();
  end
endmodule : tb_timer_channel_status
